/* File: testbench/clock_control_tb.sv */
// Self-checking bench for the clock controller
`timescale 1ns/100ps
module clock_control_tb;
	import clock_control_pkg::*;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	osc_set_s    osc_in;
	osc_set_s    osc_ready_in;
	osc_set_s    osc_enable;
	logic        osc_tick;
	logic        cpu_tick;
	logic        wdt_tick;
	int          n_mismatch;
	int          comparisons;
	int          ph = 0;
	int          oc = 0;
	int          cc = 0;
	int          wc = 0;
	int          ogap;
	int          cgap;
	int          wgap;
	int          divs [4] = '{0, 1, 3, 255};

	clock_control clock_control_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_in(osc_in), .osc_ready_in(osc_ready_in),
		.osc_enable(osc_enable), .osc_tick(osc_tick), .cpu_tick(cpu_tick),
		.wdt_tick(wdt_tick)
	);

	always #25 pclk = ~pclk;

	// ------------------------------------------------------------------
	// Oscillator stand-ins and tick spacing monitors
	// ------------------------------------------------------------------
	always @(posedge pclk) begin
		ph <= ph + 1;
		osc_in.int_fast <= (ph % 4) < 2;
		osc_in.ext_fast <= (ph % 6) < 3;
		osc_in.int_slow <= (ph % 8) < 4;
		osc_in.ext_slow <= (ph % 10) < 5;
	end

	always @(posedge pclk) begin
		oc++;
		cc++;
		wc++;
		if (osc_tick === 1'b1) begin
			ogap = oc;
			oc = 0;
		end
		if (cpu_tick === 1'b1) begin
			cgap = cc;
			cc = 0;
		end
		if (wdt_tick === 1'b1) begin
			wgap = wc;
			wc = 0;
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
		waitc(6);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		chk({err, rd}, {e, exp});
	endtask

	task automatic complete_run;
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		osc_ready_in = 4'hF;
		n_mismatch = 0;
		comparisons = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(12'h000, 32'h32, 1'b0);
		rchk(12'h004, 32'h53, 1'b0);
		rchk(12'h008, 32'h02, 1'b0);
		rchk(12'h00C, 32'h00, 1'b0);
		rchk(12'h010, 32'h00, 1'b1);
		chk({29'h0, osc_enable}, 33'h3);
		wreg(12'h000, 32'hFF);
		rchk(12'h000, 32'hB6, 1'b0);
		wreg(12'h00C, 32'h01);
		rchk(12'h000, 32'h76, 1'b0);
		wreg(12'h00C, 32'h00);
		wreg(12'h004, 32'h23);
		rchk(12'h004, 32'h63, 1'b0);
		wreg(12'h004, 32'h33);
		rchk(12'h004, 32'hF3, 1'b0);
		waitc(40);
		chk(33'(ogap), 33'd6);
		wreg(12'h004, 32'h03);
		rchk(12'h004, 32'h03, 1'b0);
		osc_ready_in <= 4'hC;
		waitc(10);
		rchk(12'h000, 32'h86, 1'b0);
		wreg(12'h004, 32'h13);
		rchk(12'h004, 32'h13, 1'b0);
		osc_ready_in <= 4'hF;
		waitc(10);
		rchk(12'h004, 32'h53, 1'b0);
		wreg(12'h000, 32'h04);
		chk({31'h0, osc_enable.int_fast, osc_enable.int_slow}, 33'h1);
		wreg(12'h000, 32'h06);
		for (int i = 0; i < 4; i++) begin
			wreg(12'h004, 32'h10 | i);
			waitc(200);
			chk(33'(ogap), 33'(4 << i));
			chk(33'(cgap), 33'(8 << i));
		end
		chk(33'(wgap), 33'd8);
		wreg(12'h004, 32'h10);
		foreach (divs[j]) begin
			wreg(12'h008, 32'(divs[j]));
			waitc(3200);
			chk(33'(cgap), 33'(4 * (divs[j] < 2 ? 1 : divs[j])));
		end
		complete_run();
	end

	initial begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		complete_run();
	end
endmodule

/* File: verilog/clock_control.sv */
// System clock source selection, pre-divider and CPU divider with APB registers
//
// Overview of operation
// - Four sources: external fast, external slow, internal fast RC, internal slow RC.
// - Internal fast RC passes a pre-divider of 1, 2, 4 or 8.
// - Selected oscillator clock divided by 1 to 255 drives the CPU.
// - Undivided oscillator clock goes to the peripherals.
// - Internal slow RC always clocks the watchdog and may be the system source.
// - External oscillator type is chosen by a separate configuration setting.
// - Bit 7 shows external fast ready; hardware driven, resets 0.
// - Bit 6 shows external slow ready; hardware driven, resets 0.
// - Bit 5 shows internal fast RC ready; hardware driven, resets 1.
// - Bit 4 shows internal slow RC ready; hardware driven, resets 1.
// - Bit 2 starts or stops the external oscillator; resets 0.
// - Bit 1 starts or stops the internal fast RC; resets 1.
// - Select code 00 picks internal slow RC, 01 internal fast RC.
// - Switch happens only when target is ready; old source keeps running.
// - Pre-divider code 00/01/10/11 gives 1/2/4/8, reset 11.
// - CPU divider 0 or 1 means undivided, else divide by value; reset 2.
`timescale 1ns/100ps
`include "clock_control_map.svh"
module clock_control (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire clock_control_pkg::osc_set_s osc_in,
	input  wire clock_control_pkg::osc_set_s osc_ready_in,
	output clock_control_pkg::osc_set_s      osc_enable,
	output logic                             osc_tick,
	output logic                             cpu_tick,
	output logic                             wdt_tick
);
	import clock_control_pkg::*;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [3:0] osc_rise;
	logic [3:0] ready_sync;
	logic       fast_tick;
	logic [3:0] src_tick;

	sync_edge #(.W(4), .RST(4'h0)) u_osc_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (osc_in),
		.level   (),
		.rise    (osc_rise)
	);

	sync_edge #(.W(4), .RST(`READY_RESET)) u_ready_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (osc_ready_in),
		.level   (ready_sync),
		.rise    ()
	);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	ctl_state_s r;
	ctl_state_s n;
	logic       setup;
	logic       wr_acc;
	logic       mapped;
	logic [7:0] rd8;
	logic [7:0] prediv_div;

	// Fast RC pre-divider; a new code is loaded only at its wrap
	assign prediv_div = 8'h01 << r.prediv;

	tick_divider #(.RESET_DIV(8'h08)) u_prediv (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick_in  (osc_rise[SRC_INT_FAST]),
		.divisor  (prediv_div),
		.tick_out (fast_tick)
	);

	// Each bit index matches a source code
	assign src_tick = {osc_rise[SRC_EXT_FAST], osc_rise[SRC_EXT_SLOW],
		fast_tick, osc_rise[SRC_INT_SLOW]};

	// CPU divider fed by the undivided oscillator pulses
	tick_divider #(.RESET_DIV(`CPU_DIVIDER_RESET)) u_cpu_div (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick_in  (r.osc_tick),
		.divisor  (r.cpu_div),
		.tick_out (cpu_tick)
	);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pwrite;

	always_comb begin
		mapped = 1'b1;
		rd8    = 8'h00;
		unique case (paddr)
			`CLOCK_CONTROL_ADDR: begin
				rd8 = {r.rdy, 1'b0, r.ext_en, r.fast_en, 1'b0};
			end
			`SOURCE_SWITCH_ADDR: begin
				rd8 = {r.active, r.sel, 2'b00, r.prediv};
			end
			`CPU_DIVIDER_ADDR: begin
				rd8 = r.cpu_div;
			end
			`EXT_OSC_CONFIG_ADDR: begin
				rd8 = {7'h00, r.cfg_slow};
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		n = r;
		if (setup) begin
			n.prdata = {24'h000000, rd8};
		end
		if (wr_acc) begin
			unique case (paddr)
				`CLOCK_CONTROL_ADDR: begin
					n.ext_en  = pwdata[`CTRL_EXT_EN_BIT];
					n.fast_en = pwdata[`CTRL_FAST_EN_BIT];
				end
				`SOURCE_SWITCH_ADDR: begin
					n.sel    = src_e'(pwdata[`SW_SEL_LSB +: 2]);
					n.prediv = pwdata[`SW_PREDIV_LSB +: 2];
				end
				`CPU_DIVIDER_ADDR: begin
					n.cpu_div = pwdata[7:0];
				end
				`EXT_OSC_CONFIG_ADDR: begin
					n.cfg_slow = pwdata[`CFG_SLOW_BIT];
				end
				default: begin
				end
			endcase
		end
		// Ready flags follow the oscillators and their enables
		n.rdy[SRC_EXT_FAST] = ready_sync[SRC_EXT_FAST] && r.ext_en && !r.cfg_slow;
		n.rdy[SRC_EXT_SLOW] = ready_sync[SRC_EXT_SLOW] && r.ext_en && r.cfg_slow;
		n.rdy[SRC_INT_FAST] = ready_sync[SRC_INT_FAST] && r.fast_en;
		n.rdy[SRC_INT_SLOW] = ready_sync[SRC_INT_SLOW];
		// Pulses carry whole cycles, so a switch between them cannot clip one
		if (r.sel != r.active && r.rdy[r.sel]) begin
			n.active = r.sel;
		end
		n.osc_tick = src_tick[r.active];
		n.wdt_tick = osc_rise[SRC_INT_SLOW];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{prdata: 32'h00000000, rdy: `READY_RESET, ext_en: 1'b0,
				fast_en: 1'b1, cfg_slow: 1'b0, sel: SRC_INT_FAST,
				active: SRC_INT_FAST, prediv: `PREDIV_RESET,
				cpu_div: `CPU_DIVIDER_RESET, osc_tick: 1'b0, wdt_tick: 1'b0};
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign prdata  = r.prdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign osc_tick = r.osc_tick;
	assign wdt_tick = r.wdt_tick;
	// The old source is left running after a switch
	assign osc_enable = '{ext_fast: r.ext_en && !r.cfg_slow,
		ext_slow: r.ext_en && r.cfg_slow, int_fast: r.fast_en,
		int_slow: 1'b1};

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence ctrl_write_s;
		wr_acc && paddr == `CLOCK_CONTROL_ADDR;
	endsequence

	sequence ctrl_read_s;
		setup && !pwrite && paddr == `CLOCK_CONTROL_ADDR;
	endsequence

	sequence blocked_select_s;
		wr_acc && paddr == `SOURCE_SWITCH_ADDR
			&& !r.rdy[pwdata[`SW_SEL_LSB +: 2]]
			&& r.active != src_e'(pwdata[`SW_SEL_LSB +: 2]);
	endsequence

	a_ext_fast_gate: assert property (r.rdy[SRC_EXT_FAST] |-> $past(r.ext_en) && !$past(r.cfg_slow))
		else $error("external fast ready without its enable");
	a_ext_slow_gate: assert property (r.rdy[SRC_EXT_SLOW] |-> $past(r.ext_en) && $past(r.cfg_slow))
		else $error("external slow ready without its enable");
	a_fast_rc_gate: assert property (r.rdy[SRC_INT_FAST] |-> $past(r.fast_en))
		else $error("fast RC ready while stopped");
	a_switch_on_ready: assert property (r.active != $past(r.active)
		|-> ($past(r.rdy) & (4'h1 << r.active)) != 4'h0 && r.active == $past(r.sel))
		else $error("switched to a source that was not ready");
	a_blocked_select: assert property (blocked_select_s ##1 !r.rdy[r.sel] |-> ##1 $stable(r.active))
		else $error("switch taken to a source that is not ready");
	a_reserved_zero: assert property (ctrl_read_s |=> prdata[3] == 1'b0 && prdata[0] == 1'b0)
		else $error("reserved control bits read nonzero");
	a_ext_enable_write: assert property (ctrl_write_s |=> r.ext_en == $past(pwdata[2])
		&& r.fast_en == $past(pwdata[1]))
		else $error("enable bits not written");
	a_osc_follows: assert property (osc_tick |-> $past(src_tick[r.active]) || $past(r.active) != r.active)
		else $error("peripheral pulse not from the active source");
	a_wdt_slow_rc: assert property (wdt_tick == $past(osc_rise[SRC_INT_SLOW]))
		else $error("watchdog pulse not from slow RC");
	a_cpu_from_osc: assert property (cpu_tick |-> $past(r.osc_tick))
		else $error("CPU pulse without an oscillator pulse");

	// ------------------------------------------------------------------
	// Register field checks
	// ------------------------------------------------------------------
	sequence sel_write_s;
		wr_acc && paddr == `SOURCE_SWITCH_ADDR;
	endsequence

	sequence div_write_s;
		wr_acc && paddr == `CPU_DIVIDER_ADDR;
	endsequence

	sequence cfg_write_s;
		wr_acc && paddr == `EXT_OSC_CONFIG_ADDR;
	endsequence

	a_select_write: assert property (sel_write_s |=>
		r.sel == $past(pwdata[`SW_SEL_LSB +: 2]))
		else $error("source select not written");
	a_prediv_write: assert property (sel_write_s |=>
		r.prediv == $past(pwdata[`SW_PREDIV_LSB +: 2]))
		else $error("pre-divider code not written");
	a_cpu_div_write: assert property (div_write_s |=>
		r.cpu_div == $past(pwdata[7:0]))
		else $error("CPU divider not written");
	a_config_write: assert property (cfg_write_s |=>
		r.cfg_slow == $past(pwdata[`CFG_SLOW_BIT]))
		else $error("oscillator type not written");
	a_enables_held: assert property (!(wr_acc && paddr == `CLOCK_CONTROL_ADDR) |=>
		$stable(r.ext_en) && $stable(r.fast_en))
		else $error("enable bits changed without a write");
	a_select_held: assert property (!(wr_acc && paddr == `SOURCE_SWITCH_ADDR) |=>
		$stable(r.sel) && $stable(r.prediv))
		else $error("select or pre-divider changed without a write");

	// ------------------------------------------------------------------
	// Ready flag and switch checks
	// ------------------------------------------------------------------
	a_fast_rc_stopped: assert property (!r.fast_en |=> !r.rdy[SRC_INT_FAST])
		else $error("fast RC ready while its enable is clear");
	a_ext_stopped: assert property (!r.ext_en |=>
		!r.rdy[SRC_EXT_FAST] && !r.rdy[SRC_EXT_SLOW])
		else $error("external source ready while the oscillator is stopped");
	a_slow_rc_lost: assert property ($fell(ready_sync[SRC_INT_SLOW]) |=>
		!r.rdy[SRC_INT_SLOW])
		else $error("slow RC ready flag kept after the oscillator dropped");
	a_switch_taken: assert property (r.sel != r.active && r.rdy[r.sel] |=>
		r.active == $past(r.sel))
		else $error("switch to a ready source not taken");

	// ------------------------------------------------------------------
	// Bus checks
	// ------------------------------------------------------------------
	sequence unmapped_access_s;
		psel && penable && paddr != `CLOCK_CONTROL_ADDR && paddr != `SOURCE_SWITCH_ADDR
			&& paddr != `CPU_DIVIDER_ADDR && paddr != `EXT_OSC_CONFIG_ADDR;
	endsequence

	a_unmapped_error: assert property (unmapped_access_s |-> pslverr)
		else $error("unmapped access without an error response");
	a_read_high_zero: assert property (setup |=> prdata[31:8] == 24'h000000)
		else $error("read data above the register byte is nonzero");
	a_read_held: assert property (!setup |=> $stable(prdata))
		else $error("read data changed outside a setup cycle");
endmodule

/* File: verilog/clock_control_map.svh */
// Register offsets, field positions and reset values of the clock controller
`ifndef CLOCK_CONTROL_MAP_SVH
`define CLOCK_CONTROL_MAP_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CLOCK_CONTROL_ADDR    12'h000
`define SOURCE_SWITCH_ADDR    12'h004
`define CPU_DIVIDER_ADDR      12'h008
`define EXT_OSC_CONFIG_ADDR   12'h00C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_EXT_EN_BIT       2
`define CTRL_FAST_EN_BIT      1
`define SW_SEL_LSB            4
`define SW_PREDIV_LSB         0
`define CFG_SLOW_BIT          0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CLOCK_CONTROL_RESET   8'h32
`define SOURCE_SWITCH_RESET   8'h53
`define CPU_DIVIDER_RESET     8'h02
`define EXT_OSC_CONFIG_RESET  8'h00
`define READY_RESET           4'h3
`define PREDIV_RESET          2'h3
`define SOURCE_RESET          2'h1

`endif

/* File: verilog/clock_control_pkg.sv */
// Types shared by the clock controller modules
package clock_control_pkg;

	// ------------------------------------------------------------------
	// Source codes, also the bit index of each source in an osc_set_s
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_INT_SLOW = 2'b00,
		SRC_INT_FAST = 2'b01,
		SRC_EXT_SLOW = 2'b10,
		SRC_EXT_FAST = 2'b11
	} src_e;

	typedef struct packed {
		logic ext_fast;
		logic ext_slow;
		logic int_fast;
		logic int_slow;
	} osc_set_s;

	// ------------------------------------------------------------------
	// State records
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] div;
		logic       tick;
	} div_state_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic [3:0]  rdy;
		logic        ext_en;
		logic        fast_en;
		logic        cfg_slow;
		src_e        sel;
		src_e        active;
		logic [1:0]  prediv;
		logic [7:0]  cpu_div;
		logic        osc_tick;
		logic        wdt_tick;
	} ctl_state_s;

endpackage

/* File: verilog/sync_edge.sv */
// Three-flop synchroniser with registered level and rising-edge pulse
`timescale 1ns/100ps
module sync_edge #(
	parameter int             W   = 4,
	parameter logic [W-1:0]   RST = '0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] rise;
	} sync_state_s;

	sync_state_s r;
	sync_state_s n;

	always_comb begin
		n      = r;
		n.s1   = din;
		n.s2   = r.s1;
		n.s3   = r.s2;
		n.rise = r.s2 & ~r.s3;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= {RST, RST, RST, {W{1'b0}}};
		end else begin
			r <= n;
		end
	end

	assign level = r.s3;
	assign rise  = r.rise;
endmodule

/* File: verilog/tick_divider.sv */
// Divides a stream of enable pulses; new divisor is taken only at a wrap
`timescale 1ns/100ps
module tick_divider #(
	parameter logic [7:0] RESET_DIV = 8'h01
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tick_in,
	input  wire logic [7:0] divisor,
	output logic            tick_out
);
	import clock_control_pkg::*;

	div_state_s r;
	div_state_s n;
	logic [7:0] last;

	always_comb begin
		last   = (r.div <= 8'h01) ? 8'h00 : r.div - 8'h01;
		n      = r;
		n.tick = 1'b0;
		if (tick_in) begin
			if (r.cnt >= last) begin
				n.cnt  = 8'h00;
				n.tick = 1'b1;
				n.div  = divisor;
			end else begin
				n.cnt = r.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{cnt: 8'h00, div: RESET_DIV, tick: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign tick_out = r.tick;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_div_wrap_point: assert property (tick_out |-> $past(tick_in) && $past(r.cnt) == $past(last))
		else $error("divider pulsed before its count was reached");
	a_div_no_skip: assert property (tick_in && r.cnt >= last |=> tick_out)
		else $error("divider missed its wrap");
endmodule
